// file: src/tcc_channel.v
// one timer/counter channel with capture mode, behind an ahb-lite slave
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_channel #(
	parameter CNT_W = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [4:0] internal_timer_clock,
	input wire [2:0] ext_clock_pin,
	input wire [2:0] chain_io_first,
	input wire io_line_first_in,
	input wire io_line_second_in,
	output reg io_line_first_out,
	output reg io_line_first_oe,
	output reg io_line_second_out,
	output reg io_line_second_oe
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// edge field: 0 none, 1 rising, 2 falling, 3 both
	function edge_hit;
		input [1:0] sel;
		input rise;
		input fall;
		begin
			edge_hit = (sel[0] & rise) | (sel[1] & fall);
		end
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [`TCC_MODE_WIDTH-1:0] channel_mode_reg;
	reg [`TCC_BMODE_WIDTH-1:0] block_mode_reg;
	reg [CNT_W-1:0] counter_value_reg;
	reg [CNT_W-1:0] capture_reg_first;
	reg [CNT_W-1:0] capture_reg_second;
	reg [CNT_W-1:0] compare_reg_third;
	reg counter_overflow_flag;
	reg load_overrun_flag;
	reg lda_flag_reg;
	reg ldb_flag_reg;
	reg cpc_flag_reg;
	reg clock_enabled_flag;
	reg running_reg;
	reg trig_pend_reg;
	reg first_armed_reg;
	reg first_unread_reg;
	reg second_unread_reg;
	reg gclk_prev_reg;

	// ------------------------------------------------------------
	// input synchronisers and edge detectors
	// ------------------------------------------------------------
	localparam NIN = 13;
	wire [NIN-1:0] raw_in;
	reg [NIN-1:0] sync1_reg;
	reg [NIN-1:0] sync2_reg;
	reg [NIN-1:0] prev_reg;
	wire [NIN-1:0] rise;
	wire [NIN-1:0] fall;
	assign raw_in = {io_line_second_in, io_line_first_in, chain_io_first, ext_clock_pin,
		internal_timer_clock};

	// two flops per input, a third holds the previous level
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= {NIN{1'b0}};
			sync2_reg <= {NIN{1'b0}};
			prev_reg <= {NIN{1'b0}};
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end
	assign rise = sync2_reg & ~prev_reg;
	assign fall = ~sync2_reg & prev_reg;

	wire io_line_first_rise = rise[11];
	wire io_line_first_fall = fall[11];
	wire io_line_second_rise = rise[12];
	wire io_line_second_fall = fall[12];

	// ------------------------------------------------------------
	// clock selection
	// ------------------------------------------------------------
	// each external clock input from its pin or a chained io line
	wire [2:0] ext_clock_input;
	assign ext_clock_input = (block_mode_reg & sync2_reg[10:8]) |
		(~block_mode_reg & sync2_reg[7:5]);

	wire [2:0] clk_sel = channel_mode_reg[`TCC_MODE_CLKSEL_LSB+2:`TCC_MODE_CLKSEL_LSB];
	wire [1:0] burst_sel = channel_mode_reg[`TCC_MODE_BURST_LSB+1:`TCC_MODE_BURST_LSB];
	wire wave = channel_mode_reg[`TCC_MODE_WAVE];
	reg sel_clk;
	reg burst_ok;

	// pick one of eight sources and the burst gate
	always @* begin
		case (clk_sel)
			3'h0, 3'h1, 3'h2, 3'h3, 3'h4: sel_clk = sync2_reg[clk_sel];
			3'h5: sel_clk = ext_clock_input[0];
			3'h6: sel_clk = ext_clock_input[1];
			default: sel_clk = ext_clock_input[2];
		endcase
		case (burst_sel)
			2'h1: burst_ok = ext_clock_input[0];
			2'h2: burst_ok = ext_clock_input[1];
			2'h3: burst_ok = ext_clock_input[2];
			default: burst_ok = 1'b1;
		endcase
	end

	// invert gate then a rising edge is one count
	wire gclk = (sel_clk ^ channel_mode_reg[`TCC_MODE_CLKINV]) & burst_ok;
	wire tick = gclk & ~gclk_prev_reg;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	wire addr_ok = hsel & htrans[1] & hready;
	wire rd_take = addr_ok & ~hwrite;
	wire [7:0] a8 = haddr[7:0];
	wire rd_stat = rd_take & (a8 == `TCC_OFS_STAT);
	wire rd_capa = rd_take & (a8 == `TCC_OFS_CAPA);
	wire rd_capb = rd_take & (a8 == `TCC_OFS_CAPB);
	wire wr_ctrl = wr_pend_reg & (wr_addr_reg == `TCC_OFS_CTRL);
	wire wr_bctrl = wr_pend_reg & (wr_addr_reg == `TCC_OFS_BCTRL);
	wire [31:0] stat_word = {15'h0000, clock_enabled_flag, 11'h000, cpc_flag_reg,
		ldb_flag_reg, lda_flag_reg, load_overrun_flag, counter_overflow_flag};
	reg [31:0] rd_mux;

	// read data chosen in the address phase, unmapped reads as zero
	always @* begin
		case (a8)
			`TCC_OFS_MODE: rd_mux = {12'h000, channel_mode_reg};
			`TCC_OFS_CV: rd_mux = {16'h0000, counter_value_reg};
			`TCC_OFS_CAPA: rd_mux = {16'h0000, capture_reg_first};
			`TCC_OFS_CAPB: rd_mux = {16'h0000, capture_reg_second};
			`TCC_OFS_CMPC: rd_mux = {16'h0000, compare_reg_third};
			`TCC_OFS_STAT: rd_mux = stat_word;
			`TCC_OFS_BMODE: rd_mux = {29'h00000000, block_mode_reg};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// zero wait states, always okay; writes land in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= addr_ok & hwrite;
			wr_addr_reg <= a8;
			if (rd_take)
				hrdata <= rd_mux;
		end
	end

	// plain read/write registers; capture registers writable only in wave mode
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_mode_reg <= `TCC_MODE_RESET;
			block_mode_reg <= `TCC_BMODE_RESET;
			compare_reg_third <= `TCC_CNT_RESET;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == `TCC_OFS_MODE)
				channel_mode_reg <= hwdata[`TCC_MODE_WIDTH-1:0];
			if (wr_addr_reg == `TCC_OFS_BMODE)
				block_mode_reg <= hwdata[`TCC_BMODE_WIDTH-1:0];
			if (wr_addr_reg == `TCC_OFS_CMPC)
				compare_reg_third <= hwdata[CNT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// triggers
	// ------------------------------------------------------------
	wire sw_trig = wr_ctrl & hwdata[`TCC_CTRL_SOFTWARE_TRIGGER_BIT];
	wire sync_trig = wr_bctrl & hwdata[`TCC_BCTRL_SYNC];
	wire [1:0] et_edge = channel_mode_reg[`TCC_MODE_ETEDGE_LSB+1:`TCC_MODE_ETEDGE_LSB];
	wire [1:0] ev_sel = channel_mode_reg[`TCC_MODE_EVSEL_LSB+1:`TCC_MODE_EVSEL_LSB];
	wire [CNT_W-1:0] cnt_inc = counter_value_reg + {{(CNT_W-1){1'b0}}, 1'b1};
	wire counting = clock_enabled_flag & running_reg & tick;
	wire [CNT_W-1:0] cnt_new = trig_pend_reg ? `TCC_CNT_RESET : cnt_inc;
	// match seen when a count lands on the third register
	wire cpc_hit = counting & (cnt_new == compare_reg_third);
	reg ev_rise;
	reg ev_fall;

	// external source: first/second io in capture event select in wave
	always @* begin
		if (!wave) begin
			ev_rise = channel_mode_reg[`TCC_MODE_ETLINE] ? rise[11] : io_line_second_rise;
			ev_fall = channel_mode_reg[`TCC_MODE_ETLINE] ? fall[11] : io_line_second_fall;
		end else begin
			case (ev_sel)
				2'h1: begin
					ev_rise = (block_mode_reg[0] ? rise[8] : rise[5]);
					ev_fall = (block_mode_reg[0] ? fall[8] : fall[5]);
				end
				2'h2: begin
					ev_rise = (block_mode_reg[1] ? rise[9] : rise[6]);
					ev_fall = (block_mode_reg[1] ? fall[9] : fall[6]);
				end
				2'h3: begin
					ev_rise = (block_mode_reg[2] ? rise[10] : rise[7]);
					ev_fall = (block_mode_reg[2] ? fall[10] : fall[7]);
				end
				default: begin
					ev_rise = io_line_second_rise;
					ev_fall = io_line_second_fall;
				end
			endcase
		end
	end

	wire ext_trig = edge_hit(et_edge, ev_rise, ev_fall) &
		(~wave | channel_mode_reg[`TCC_MODE_EVTRG]);
	wire cpc_trig = cpc_hit & channel_mode_reg[`TCC_MODE_COMPARE_TRIGGER_ENABLE];
	wire any_trig = sw_trig | sync_trig | ext_trig | cpc_trig;

	// ------------------------------------------------------------
	// capture loads
	// ------------------------------------------------------------
	wire [1:0] lda_sel = channel_mode_reg[`TCC_MODE_LDA_LSB+1:`TCC_MODE_LDA_LSB];
	wire [1:0] ldb_sel = channel_mode_reg[`TCC_MODE_LDB_LSB+1:`TCC_MODE_LDB_LSB];
	// alternate: first only when not yet armed, second only after first
	wire load_a = ~wave & edge_hit(lda_sel, io_line_first_rise, io_line_first_fall) & ~first_armed_reg;
	wire load_b = ~wave & edge_hit(ldb_sel, io_line_first_rise, io_line_first_fall) & first_armed_reg;
	wire stop_ev = (~wave & load_b) | (wave & cpc_hit);
	wire stop_now = stop_ev & channel_mode_reg[`TCC_MODE_STOP];
	wire dis_now = stop_ev & channel_mode_reg[`TCC_MODE_DIS];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capture_reg_first <= `TCC_CNT_RESET;
			capture_reg_second <= `TCC_CNT_RESET;
			first_armed_reg <= 1'b0;
			first_unread_reg <= 1'b0;
			second_unread_reg <= 1'b0;
			load_overrun_flag <= 1'b0;
		end else begin
			if (load_a) begin
				capture_reg_first <= counter_value_reg;
				first_armed_reg <= 1'b1;
			end else if (load_b | any_trig) begin
				first_armed_reg <= 1'b0;
			end
			if (load_b)
				capture_reg_second <= counter_value_reg;
			if (wr_pend_reg & wave & (wr_addr_reg == `TCC_OFS_CAPA))
				capture_reg_first <= hwdata[CNT_W-1:0];
			if (wr_pend_reg & wave & (wr_addr_reg == `TCC_OFS_CAPB))
				capture_reg_second <= hwdata[CNT_W-1:0];
			// a load beats a read in the same cycle
			first_unread_reg <= load_a | (first_unread_reg & ~rd_capa);
			second_unread_reg <= load_b | (second_unread_reg & ~rd_capb);
			// overwrite an unread value and flag it; set wins over read clear
			load_overrun_flag <= (load_a & first_unread_reg) | (load_b & second_unread_reg) |
				(load_overrun_flag & ~rd_stat);
		end
	end

	// ------------------------------------------------------------
	// clock control and counter
	// ------------------------------------------------------------
	wire cmd_en = wr_ctrl & hwdata[`TCC_CTRL_CLOCK_ENABLE_CMD];
	wire cmd_dis = wr_ctrl & hwdata[`TCC_CTRL_CLOCK_DISABLE_CMD];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_enabled_flag <= 1'b0;
			running_reg <= 1'b0;
			trig_pend_reg <= 1'b0;
			counter_value_reg <= `TCC_CNT_RESET;
			counter_overflow_flag <= 1'b0;
			lda_flag_reg <= 1'b0;
			ldb_flag_reg <= 1'b0;
			cpc_flag_reg <= 1'b0;
			gclk_prev_reg <= 1'b0;
		end else begin
			gclk_prev_reg <= gclk;
			// disable wins over enable; only a command re-enables
			if (cmd_dis | dis_now)
				clock_enabled_flag <= 1'b0;
			else if (cmd_en)
				clock_enabled_flag <= 1'b1;
			// start and stop act only while enabled
			if (clock_enabled_flag) begin
				if (any_trig)
					running_reg <= 1'b1;
				else if (stop_now)
					running_reg <= 1'b0;
			end
			// trigger waits for the next counting edge
			if (clock_enabled_flag & any_trig)
				trig_pend_reg <= 1'b1;
			else if (counting)
				trig_pend_reg <= 1'b0;
			if (counting)
				counter_value_reg <= cnt_new;
			// sticky flags, set wins over the status read clear
			counter_overflow_flag <= (counting & ~trig_pend_reg & (&counter_value_reg)) |
				(counter_overflow_flag & ~rd_stat);
			lda_flag_reg <= load_a | (lda_flag_reg & ~rd_stat);
			ldb_flag_reg <= load_b | (ldb_flag_reg & ~rd_stat);
			cpc_flag_reg <= cpc_hit | (cpc_flag_reg & ~rd_stat);
		end
	end

	// ------------------------------------------------------------
	// io direction
	// ------------------------------------------------------------
	// capture: both inputs; wave: first drives, second unless used as event
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_line_first_out <= 1'b0;
			io_line_first_oe <= 1'b0;
			io_line_second_out <= 1'b0;
			io_line_second_oe <= 1'b0;
		end else begin
			io_line_first_out <= 1'b0;
			io_line_second_out <= 1'b0;
			io_line_first_oe <= wave;
			io_line_second_oe <= wave & (ev_sel != 2'h0);
		end
	end

endmodule
`default_nettype wire

// file: src/tcc_defs.vh
// register offsets, field positions and reset values of the timer channel
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_MODE 8'h04
`define TCC_OFS_CV 8'h10
`define TCC_OFS_CAPA 8'h14
`define TCC_OFS_CAPB 8'h18
`define TCC_OFS_CMPC 8'h1c
`define TCC_OFS_STAT 8'h20
`define TCC_OFS_BCTRL 8'hc0
`define TCC_OFS_BMODE 8'hc4

// ------------------------------------------------------------
// channel control register bits (write only)
// ------------------------------------------------------------
`define TCC_CTRL_CLOCK_ENABLE_CMD 0
`define TCC_CTRL_CLOCK_DISABLE_CMD 1
`define TCC_CTRL_SOFTWARE_TRIGGER_BIT 2

// ------------------------------------------------------------
// channel mode register fields
// ------------------------------------------------------------
`define TCC_MODE_CLKSEL_LSB 0
`define TCC_MODE_CLKINV 3
`define TCC_MODE_BURST_LSB 4
`define TCC_MODE_STOP 6
`define TCC_MODE_DIS 7
`define TCC_MODE_ETEDGE_LSB 8
`define TCC_MODE_ETLINE 10
`define TCC_MODE_EVSEL_LSB 10
`define TCC_MODE_EVTRG 12
`define TCC_MODE_COMPARE_TRIGGER_ENABLE 14
`define TCC_MODE_WAVE 15
`define TCC_MODE_LDA_LSB 16
`define TCC_MODE_LDB_LSB 18
`define TCC_MODE_WIDTH 20
`define TCC_MODE_RESET 20'h00000

// ------------------------------------------------------------
// status register bits and block registers
// ------------------------------------------------------------
`define TCC_STAT_COVF 0
`define TCC_STAT_LOVR 1
`define TCC_STAT_LDA 2
`define TCC_STAT_LDB 3
`define TCC_STAT_CPC 4
`define TCC_STAT_CLOCK_ENABLED_FLAG 16
`define TCC_BCTRL_SYNC 0
`define TCC_BMODE_WIDTH 3
`define TCC_BMODE_RESET 3'h0
`define TCC_CNT_RESET 16'h0000

`endif

// file: testbench/tcc_channel_asserts.sv
// assertion checker on the ports of the timer channel
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_channel_asserts #(
	parameter CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic io_line_first_oe,
	input wire logic io_line_second_oe
);
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [19:0] mode_sh_reg;
	logic [15:0] cmp_sh_reg;
	logic [2:0] bmode_sh_reg;
	logic clock_enable_cmd_sh_reg;
	wire rd_take = hsel && htrans[1] && hready && !hwrite;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// shadow copies of writable state, updated where each write data phase ends
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			mode_sh_reg <= 20'h00000;
			cmp_sh_reg <= 16'h0000;
			bmode_sh_reg <= 3'h0;
			clock_enable_cmd_sh_reg <= 1'b0;
		end else begin
			wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
			wr_addr_reg <= haddr[7:0];
			if (wr_pend_reg && hready) begin
				if (wr_addr_reg == `TCC_OFS_MODE) mode_sh_reg <= hwdata[19:0];
				if (wr_addr_reg == `TCC_OFS_CMPC) cmp_sh_reg <= hwdata[15:0];
				if (wr_addr_reg == `TCC_OFS_BMODE) bmode_sh_reg <= hwdata[2:0];
				if (wr_addr_reg == `TCC_OFS_CTRL && (hwdata[1] || hwdata[0])) clock_enable_cmd_sh_reg <= !hwdata[1];
			end
		end
	end
	chk_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp)
		else $error("error response seen");
	chk_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
		else $error("read data changed without a read");
	chk_mode_readback: assert property (rd_take && haddr[7:0] == `TCC_OFS_MODE
		|=> hrdata == {12'h000, $past(mode_sh_reg)})
		else $error("mode read differs from last write");
	chk_bmode_readback: assert property (rd_take && haddr[7:0] == `TCC_OFS_BMODE
		|=> hrdata == {29'h0, $past(bmode_sh_reg)})
		else $error("block mode read differs from last write");
	chk_cmp_readback: assert property (rd_take && haddr[7:0] == `TCC_OFS_CMPC
		|=> hrdata[15:0] == $past(cmp_sh_reg))
		else $error("compare read differs from last write");
	chk_clock_enable_cmd_status: assert property (rd_take && haddr[7:0] == `TCC_OFS_STAT && !mode_sh_reg[7]
		|=> hrdata[`TCC_STAT_CLOCK_ENABLED_FLAG] == $past(clock_enable_cmd_sh_reg))
		else $error("clock enabled flag differs from commands");
	chk_first_oe_mode: assert property ($stable(mode_sh_reg)
		|-> io_line_first_oe == mode_sh_reg[15])
		else $error("first io enable differs from mode");
	chk_second_oe_mode: assert property ($stable(mode_sh_reg)
		|-> io_line_second_oe == (mode_sh_reg[15] && mode_sh_reg[11:10] != 2'b00))
		else $error("second io enable differs from mode");
endmodule
bind tcc_channel tcc_channel_asserts #(.CNT_W(CNT_W)) tcc_channel_asserts_i (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.io_line_first_oe(io_line_first_oe), .io_line_second_oe(io_line_second_oe));
`default_nettype wire

// file: testbench/tcc_channel_tb_top.sv
// self-checking bench for the timer channel: bus tasks and directed sequences
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_channel_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] r;
	wire [31:0] hrdata;
	wire hreadyout, hresp, io_a, io_b, oa, oae, ob, obe;
	wire [4:0] itc;
	wire [2:0] pins, chain;
	int err_count = 0;
	int n_checks = 0;
	always #2 hclk = ~hclk;
	tcc_channel tcc_channel_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .internal_timer_clock(itc),
		.ext_clock_pin(pins), .chain_io_first(chain), .io_line_first_in(io_a),
		.io_line_second_in(io_b), .io_line_first_out(oa), .io_line_first_oe(oae),
		.io_line_second_out(ob), .io_line_second_oe(obe));
	tcc_ext_src tcc_ext_src_i (.hclk(hclk), .internal_timer_clock(itc), .ext_clock_pin(pins),
		.chain_io_first(chain), .io_line_first_in(io_a), .io_line_second_in(io_b));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// single ahb-lite transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge hclk);
		err_count++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values, unmapped place, readback
		rd(`TCC_OFS_MODE, 32'hffffffff, 32'h0);
		rd(`TCC_OFS_CV, 32'hffffffff, 32'h0);
		rd(`TCC_OFS_STAT, 32'hffffffff, 32'h0);
		wr(8'h30, 32'h12345678);
		rd(8'h30, 32'hffffffff, 32'h0);
		wr(`TCC_OFS_CMPC, 32'h0000a5c3);
		rd(`TCC_OFS_CMPC, 32'h0000ffff, 32'h0000a5c3);
		wr(`TCC_OFS_BMODE, 32'h5);
		rd(`TCC_OFS_BMODE, 32'h7, 32'h5);
		wr(`TCC_OFS_BMODE, 32'h0);
		// capture mode on clock pin 0, load first on rise, second on fall
		wr(`TCC_OFS_MODE, 32'h00090005);
		wr(`TCC_OFS_CTRL, 32'h1);
		wr(`TCC_OFS_CTRL, 32'h4);
		tcc_ext_src_i.pulse(1'b0, 3);
		rd(`TCC_OFS_CV, 32'hffff, 32'h2);
		tcc_ext_src_i.set_io(1'b1);
		tcc_ext_src_i.pulse(1'b0, 2);
		tcc_ext_src_i.set_io(1'b0);
		tcc_ext_src_i.pulse(1'b0, 1);
		tcc_ext_src_i.set_io(1'b1);
		rd(`TCC_OFS_STAT, 32'h00010002, 32'h00010002);
		rd(`TCC_OFS_CAPA, 32'hffff, 32'h5);
		rd(`TCC_OFS_CAPB, 32'hffff, 32'h4);
		// inverted clock counts on falling pin edges
		tcc_ext_src_i.set_clk(1'b0, 1'b1);
		wr(`TCC_OFS_MODE, 32'h0000000d);
		tcc_ext_src_i.set_clk(1'b0, 1'b0);
		rd(`TCC_OFS_CV, 32'hffff, 32'h7);
		tcc_ext_src_i.set_clk(1'b0, 1'b1);
		rd(`TCC_OFS_CV, 32'hffff, 32'h7);
		// block sync acts as a trigger
		wr(`TCC_OFS_BCTRL, 32'h1);
		tcc_ext_src_i.set_clk(1'b0, 1'b0);
		rd(`TCC_OFS_CV, 32'hffff, 32'h0);
		// rising first io line as external trigger
		wr(`TCC_OFS_MODE, 32'h00000505);
		tcc_ext_src_i.pulse(1'b0, 3);
		tcc_ext_src_i.set_io(1'b0);
		tcc_ext_src_i.set_io(1'b1);
		tcc_ext_src_i.pulse(1'b0, 1);
		rd(`TCC_OFS_CV, 32'hffff, 32'h0);
		// chained line replaces clock pin 0
		wr(`TCC_OFS_BMODE, 32'h1);
		tcc_ext_src_i.pulse(1'b1, 3);
		tcc_ext_src_i.pulse(1'b0, 2);
		rd(`TCC_OFS_CV, 32'hffff, 32'h3);
		// compare match with third register retriggers
		wr(`TCC_OFS_CMPC, 32'h2);
		wr(`TCC_OFS_MODE, 32'h00004005);
		wr(`TCC_OFS_CTRL, 32'h4);
		tcc_ext_src_i.pulse(1'b1, 5);
		rd(`TCC_OFS_CV, 32'hffff, 32'h1);
		// disabled clock ignores triggers and edges
		wr(`TCC_OFS_CTRL, 32'h2);
		rd(`TCC_OFS_STAT, 32'h00010000, 32'h0);
		wr(`TCC_OFS_CTRL, 32'h4);
		tcc_ext_src_i.pulse(1'b1, 2);
		rd(`TCC_OFS_CV, 32'hffff, 32'h1);
		// burst gate on clock pin 1 passes counts only while high
		wr(`TCC_OFS_MODE, 32'h00000025);
		wr(`TCC_OFS_CTRL, 32'h1);
		wr(`TCC_OFS_CTRL, 32'h4);
		tcc_ext_src_i.set_gate(1'b1);
		tcc_ext_src_i.pulse(1'b1, 3);
		tcc_ext_src_i.set_gate(1'b0);
		tcc_ext_src_i.pulse(1'b1, 2);
		rd(`TCC_OFS_CV, 32'hffff, 32'h2);
		// second load stops the clock, a trigger restarts it
		wr(`TCC_OFS_MODE, 32'h00090045);
		wr(`TCC_OFS_CTRL, 32'h4);
		tcc_ext_src_i.pulse(1'b1, 2);
		tcc_ext_src_i.set_io(1'b0);
		tcc_ext_src_i.set_io(1'b1);
		tcc_ext_src_i.set_io(1'b0);
		tcc_ext_src_i.pulse(1'b1, 2);
		rd(`TCC_OFS_CV, 32'hffff, 32'h1);
		rd(`TCC_OFS_CAPB, 32'hffff, 32'h1);
		wr(`TCC_OFS_CTRL, 32'h4);
		tcc_ext_src_i.pulse(1'b1, 1);
		rd(`TCC_OFS_CV, 32'hffff, 32'h0);
		// waveform: event on pin 1 triggers, compare match disables
		wr(`TCC_OFS_MODE, 32'h00009985);
		tcc_ext_src_i.pulse(1'b1, 1);
		tcc_ext_src_i.set_gate(1'b1);
		tcc_ext_src_i.pulse(1'b1, 1);
		rd(`TCC_OFS_CV, 32'hffff, 32'h0);
		tcc_ext_src_i.pulse(1'b1, 3);
		rd(`TCC_OFS_CV, 32'hffff, 32'h2);
		rd(`TCC_OFS_STAT, 32'h00010000, 32'h0);
		// first internal timer clock keeps the counter moving
		wr(`TCC_OFS_MODE, 32'h0);
		wr(`TCC_OFS_CTRL, 32'h1);
		wr(`TCC_OFS_CTRL, 32'h4);
		repeat (80) @(posedge hclk);
		bus(1'b0, `TCC_OFS_CV, 32'h0, r);
		chk(r > 32'h7 && r < 32'h10, 32'h1);
		// waveform mode drives both io lines
		wr(`TCC_OFS_MODE, 32'h00008400);
		repeat (3) @(posedge hclk);
		chk({28'h0, oae, obe, oa, ob}, 32'hc);
		report_and_stop;
	end
endmodule
`default_nettype wire

// file: testbench/tcc_ext_src.sv
// external sources for the timer channel: timer clocks, clock pins, chain and io lines
`timescale 1ns/1ps
`default_nettype none
module tcc_ext_src (
	input wire logic hclk,
	output logic [4:0] internal_timer_clock,
	output logic [2:0] ext_clock_pin,
	output logic [2:0] chain_io_first,
	output logic io_line_first_in,
	output logic io_line_second_in
);
	logic [6:0] div = 7'h00;
	initial begin
		ext_clock_pin = 3'h0;
		chain_io_first = 3'h0;
		io_line_first_in = 1'b0;
		io_line_second_in = 1'b0;
	end
	// free-running internal clocks, power-of-two divisions of the master clock
	always @(posedge hclk) begin
		div <= div + 7'h01;
	end
	assign internal_timer_clock = div[6:2];
	// one level on clock pin 0 or chained line 0, held long enough to be seen
	task automatic set_clk(input logic sel, input logic v);
		@(posedge hclk);
		if (sel) chain_io_first[0] <= v;
		else ext_clock_pin[0] <= v;
		repeat (5) @(posedge hclk);
	endtask
	task automatic pulse(input logic sel, input int n);
		repeat (n) begin
			set_clk(sel, 1'b1);
			set_clk(sel, 1'b0);
		end
	endtask
	// first io line level, held past several master clocks
	task automatic set_io(input logic v);
		@(posedge hclk);
		io_line_first_in <= v;
		repeat (5) @(posedge hclk);
	endtask
	// level on clock pin 1, used as burst gate or external event
	task automatic set_gate(input logic v);
		@(posedge hclk);
		ext_clock_pin[1] <= v;
		repeat (5) @(posedge hclk);
	endtask
endmodule
`default_nettype wire
